// ==== logic/uhr_cfg.svh ====
// uhr_cfg.svh: offsets, fields, codes and timing counts of the hub block
// assumes a 100 MHz clock and full-speed bit times of 1/12 us
`ifndef UHR_CFG_SVH
`define UHR_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UHR_A_CFGA 8'h48
`define UHR_A_CFGB 8'h4C
`define UHR_A_HUB  8'h50
`define UHR_A_P0   8'h54
`define UHR_A_P1   8'h58
// ----------------------------------------
// field positions
// ----------------------------------------
`define UHR_F_SCHEME  8
`define UHR_F_ALWAYS  9
`define UHR_F_GSCHEME 11
`define UHR_F_GOFF    12
`define UHR_F_MASK0   17
`define UHR_F_ALLOFF  0
`define UHR_F_HOVL    1
`define UHR_F_WAKEEN  15
`define UHR_F_ALLON   16
`define UHR_F_HCHG    17
`define UHR_F_WAKECLR 31
`define UHR_F_CONN    0
`define UHR_F_EN      1
`define UHR_F_SUSP    2
`define UHR_F_POVL    3
`define UHR_F_RES     4
`define UHR_F_PON     8
`define UHR_F_POFF    9
`define UHR_F_PCHG    16
// ----------------------------------------
// completion codes
// ----------------------------------------
`define UHR_C_OK    4'h0
`define UHR_C_CRC   4'h1
`define UHR_C_STUFF 4'h2
`define UHR_C_TOG   4'h3
`define UHR_C_STALL 4'h4
`define UHR_C_NORSP 4'h5
`define UHR_C_PIDCK 4'h6
`define UHR_C_PIDUX 4'h7
`define UHR_C_OVER  4'h8
`define UHR_C_UNDER 4'h9
`define UHR_C_BOVR  4'hC
`define UHR_C_BUND  4'hD
`define UHR_C_EOF   4'hE
`define UHR_C_NAK   4'hF
// ----------------------------------------
// timing
// ----------------------------------------
`define UHR_CLK_MHZ 100
`define UHR_BIT_MHZ 12
`define UHR_SE0_BITS 16
`define UHR_J_BITS 8
`define UHR_ATT_BITS 30
`define UHR_CYC(b) (((b)*`UHR_CLK_MHZ+`UHR_BIT_MHZ-1)/`UHR_BIT_MHZ)
`define UHR_SE0_CYC `UHR_CYC(`UHR_SE0_BITS)
`define UHR_J_CYC `UHR_CYC(`UHR_J_BITS)
`define UHR_ATT_CYC `UHR_CYC(`UHR_ATT_BITS)
`endif

// ==== logic/uhr_pkg.sv ====
// uhr_pkg: types of the hub and completion-status block
// assumes uhr_cfg.svh supplies the numeric constants
package uhr_pkg;
  typedef enum logic [1:0] {
    CTRL_BUS_RESET = 2'h0,
    CTRL_WAKE_SIG  = 2'h1,
    CTRL_RUNNING   = 2'h2,
    CTRL_SLEEP     = 2'h3
  } uhr_ctrl_e;
  typedef enum logic [2:0] {
    EOP_IDLE = 3'h1,
    EOP_SE0  = 3'h2,
    EOP_J    = 3'h4
  } uhr_eop_e;
  typedef enum logic [1:0] {
    PH_IN_DATA  = 2'h0,
    PH_OUT_DATA = 2'h1,
    PH_OUT_HS   = 2'h2
  } uhr_phase_e;
  typedef struct packed {
    logic dp;
    logic dm;
  } uhr_line_s;
  typedef struct packed {
    logic       done;
    uhr_phase_e phase;
    logic       iso;
    logic       eof;
    logic       timeout;
    logic       crc;
    logic       stuff;
    logic       pid_chk;
    logic       pid_unx;
    logic       buf_ovr;
    logic       buf_und;
    logic       toggle;
    logic       nak;
    logic       stall;
    logic       cnt_over;
    logic       cnt_under;
  } uhr_eng_s;
  typedef struct packed {
    logic scheme, always_on, g_scheme, g_off;
    logic [1:0] mask;
    logic global_on, ovl_chg, wake_en;
    logic [1:0] port_pwr, sup, conn, en, susp, ls, chg, drv;
    logic [2:0] ovl_sy;
    logic ovl_f;
    logic [1:0][2:0] dp_sy, dm_sy;
    logic [1:0] dp_f, dm_f;
    logic [1:0][8:0] att;
    uhr_eop_e eop;
    logic [7:0] eop_cnt;
    logic eop_res;
    uhr_ctrl_e ctrl_prev;
    logic [6:0] acc;
    logic tick, pkt_ok;
    logic [3:0] result;
    logic retire, ack, force_stuff, und_pend;
    logic wake_irq, wake_req;
    uhr_line_s [1:0] line;
    logic [31:0] rdata;
  } uhr_state_s;
endpackage : uhr_pkg

// ==== logic/uhr_top.sv ====
// uhr_top: completion-status encoder and two-port root hub
// assumes engine flags and controller state come from the same clock
//
// Operation
// (R1) code 0000 for ack or good isochronous data
// (R2) 0001 crc, 0010 bit stuff, 0110 pid check failure
// (R3) 0100 on stall, or nak after isochronous in
// (R4) 0101 on response time-out
// (R5) 0111 on unexpected or undefined pid
// (R6) 1000 too many, 1001 too few bytes; 1010/1011 never made
// (R7) 1100 in buffer overrun, 1101 out buffer underrun
// (R8) 1110 end-of-frame abort, 1111 nak received
// (R9) in data status by fixed priority, always retired
// (R10) ack only on toggle mismatch, byte count error, success
// (R11) out underrun forces stuff error, 1101, waits for time-out
// (R12) out handshake status by priority, always retired
// (R13) software commands are write-one bits in hub and port regs
// (R14) switching scheme from config bits and port mask
// (R15) overload pin shown in hub flag and per-port in per-port mode
// (R16) overload sets change flag and drops power unless always on
// (R17) bus reset state clears all but the config registers
// (R18) sleep keeps state, stops packets and the 12 MHz tick
// (R19) wake state drives k on enabled awake ports, then ls eop
// (R20) wakeup events while asleep raise interrupt and wake request
// (R21) ls eop 16 bits se0, 8 bits j, on sof and after wake
// (R22) powered ports only; se0 none, dp full, dm low speed
// (R23) attach or detach after 30 bit times stable
//
// Local design decisions: strobed register access and the register offsets.
`include "uhr_cfg.svh"
`timescale 1ns/1ps
module uhr_top (
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  input  uhr_pkg::uhr_ctrl_e         ctrl_state_in,
  input  wire logic                  sof_request_in,
  input  uhr_pkg::uhr_eng_s          eng_in,
  output logic      [3:0]            result_out,
  output logic                       retire_out,
  output logic                       ack_out,
  output logic                       force_stuff_out,
  input  wire logic                  overload_sense_in,
  input  uhr_pkg::uhr_line_s [1:0]   line_in,
  output uhr_pkg::uhr_line_s [1:0]   line_out,
  output logic      [1:0]            line_oe_out,
  output logic                       global_supply_switch_out,
  output logic      [1:0]            port_supply_out,
  output logic                       bit_tick_out,
  output logic                       packets_allowed_out,
  output logic                       wake_seen_interrupt_out,
  output logic                       wake_request_out
);
  uhr_pkg::uhr_state_s st_r;
  uhr_pkg::uhr_state_s st_nxt;

  function automatic uhr_pkg::uhr_state_s rst_val();
    uhr_pkg::uhr_state_s r;
    r = '0;
    r.eop = uhr_pkg::EOP_IDLE;
    r.ctrl_prev = uhr_pkg::CTRL_BUS_RESET;
    return r;
  endfunction : rst_val

  logic       perr;
  logic [3:0] pcode;
  logic       ovl_rise;
  logic       wake_ev;
  logic       se0;
  logic       kst;
  logic       eop_go;
  logic [1:0] pa;
  logic       psel;
  uhr_pkg::uhr_state_s keep;

  always_comb begin
    st_nxt = st_r;
    keep = st_r;
    st_nxt.retire = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.force_stuff = 1'b0;
    st_nxt.wake_irq = 1'b0;
    st_nxt.rdata = 32'h0;
    wake_ev = 1'b0;
    se0 = 1'b0;
    kst = 1'b0;
    pa = 2'h0;
    psel = 1'b0;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // stage 0 feeds stage 1 only; stages 1 and 2 must agree
    st_nxt.ovl_sy = {st_r.ovl_sy[1:0], overload_sense_in};
    if (st_r.ovl_sy[1] == st_r.ovl_sy[2]) begin
      st_nxt.ovl_f = st_r.ovl_sy[2];
    end
    ovl_rise = (st_r.ovl_sy[1] == st_r.ovl_sy[2]) & st_r.ovl_sy[2]
               & ~st_r.ovl_f & ~st_r.g_off;
    for (int i = 0; i < 2; i++) begin
      st_nxt.dp_sy[i] = {st_r.dp_sy[i][1:0], line_in[i].dp};
      st_nxt.dm_sy[i] = {st_r.dm_sy[i][1:0], line_in[i].dm};
      if (st_r.dp_sy[i][1] == st_r.dp_sy[i][2]) begin
        st_nxt.dp_f[i] = st_r.dp_sy[i][2];
      end
      if (st_r.dm_sy[i][1] == st_r.dm_sy[i][2]) begin
        st_nxt.dm_f[i] = st_r.dm_sy[i][2];
      end
    end
    // ----------------------------------------
    // completion status
    // ----------------------------------------
    perr = eng_in.stuff | eng_in.pid_chk | eng_in.pid_unx | eng_in.crc;
    if (eng_in.stuff) begin
      pcode = `UHR_C_STUFF; // [R2]
    end else if (eng_in.pid_chk) begin
      pcode = `UHR_C_PIDCK; // [R2]
    end else if (eng_in.pid_unx) begin
      pcode = `UHR_C_PIDUX; // [R5]
    end else begin
      pcode = `UHR_C_CRC; // [R2]
    end
    if (eng_in.done) begin
      case (eng_in.phase)
        uhr_pkg::PH_IN_DATA: begin
          st_nxt.retire = 1'b1; // [R9]
          if (eng_in.eof) begin
            st_nxt.result = `UHR_C_EOF; // [R8]
          end else if (eng_in.timeout) begin
            st_nxt.result = `UHR_C_NORSP; // [R4]
          end else if (perr) begin
            st_nxt.result = pcode;
          end else if (eng_in.buf_ovr) begin
            st_nxt.result = `UHR_C_BOVR; // [R7]
          end else if (eng_in.toggle) begin
            st_nxt.result = `UHR_C_TOG;
            st_nxt.ack = 1'b1; // [R10]
          end else if (eng_in.stall | eng_in.nak) begin
            // nak after an isochronous in token reads as stall
            st_nxt.result = (eng_in.stall | eng_in.iso) ? `UHR_C_STALL
                                                        : `UHR_C_NAK; // [R3] [R8]
          end else if (eng_in.cnt_over | eng_in.cnt_under) begin
            st_nxt.result = eng_in.cnt_over ? `UHR_C_OVER : `UHR_C_UNDER; // [R6]
            st_nxt.ack = 1'b1; // [R10]
          end else begin
            st_nxt.result = `UHR_C_OK; // [R1]
            st_nxt.ack = 1'b1; // [R10]
          end
        end
        uhr_pkg::PH_OUT_DATA: begin
          if (eng_in.eof) begin
            st_nxt.result = `UHR_C_EOF;
            st_nxt.retire = 1'b1;
          end else if (eng_in.buf_und) begin
            // not retired: the handshake time-out closes it later
            st_nxt.result = `UHR_C_BUND; // [R11] [R7]
            st_nxt.force_stuff = 1'b1; // [R11]
            st_nxt.und_pend = 1'b1;
          end
        end
        uhr_pkg::PH_OUT_HS: begin
          st_nxt.retire = 1'b1; // [R12]
          st_nxt.und_pend = 1'b0;
          if (eng_in.eof) begin
            st_nxt.result = `UHR_C_EOF; // [R12]
          end else if (eng_in.timeout) begin
            st_nxt.result = st_r.und_pend ? `UHR_C_BUND : `UHR_C_NORSP; // [R12]
          end else if (perr) begin
            st_nxt.result = pcode; // [R12]
          end else if (eng_in.stall) begin
            st_nxt.result = `UHR_C_STALL; // [R12]
          end else if (eng_in.nak) begin
            st_nxt.result = `UHR_C_NAK; // [R12]
          end else begin
            st_nxt.result = `UHR_C_OK; // [R12]
          end
        end
        default: begin
          st_nxt.retire = 1'b0;
        end
      endcase
    end
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr_in) begin
      case (addr_in)
        `UHR_A_CFGA: begin
          st_nxt.scheme = wdata_in[`UHR_F_SCHEME];
          st_nxt.always_on = wdata_in[`UHR_F_ALWAYS];
          st_nxt.g_scheme = wdata_in[`UHR_F_GSCHEME];
          st_nxt.g_off = wdata_in[`UHR_F_GOFF];
        end
        `UHR_A_CFGB: begin
          st_nxt.mask = wdata_in[`UHR_F_MASK0+:2];
        end
        `UHR_A_HUB: begin
          if (wdata_in[`UHR_F_ALLOFF]) st_nxt.global_on = 1'b0; // [R13]
          if (wdata_in[`UHR_F_ALLON]) st_nxt.global_on = 1'b1; // [R13]
          if (wdata_in[`UHR_F_HCHG]) st_nxt.ovl_chg = 1'b0;
          if (wdata_in[`UHR_F_WAKEEN]) st_nxt.wake_en = 1'b1;
          if (wdata_in[`UHR_F_WAKECLR]) st_nxt.wake_en = 1'b0;
        end
        `UHR_A_P0, `UHR_A_P1: begin
          psel = (addr_in == `UHR_A_P1);
          if (wdata_in[`UHR_F_PCHG]) st_nxt.chg[psel] = 1'b0;
          if (wdata_in[`UHR_F_PON]) st_nxt.port_pwr[psel] = 1'b1; // [R13]
          if (wdata_in[`UHR_F_POFF]) st_nxt.port_pwr[psel] = 1'b0; // [R13]
          // commands to an unattached port are dropped and flagged
          if (|wdata_in[`UHR_F_RES:`UHR_F_CONN]) begin
            if (!st_r.conn[psel]) begin
              st_nxt.chg[psel] = 1'b1;
            end else begin
              if (wdata_in[`UHR_F_CONN]) st_nxt.en[psel] = 1'b0; // [R13]
              if (wdata_in[`UHR_F_EN]) st_nxt.en[psel] = 1'b1; // [R13]
              if (wdata_in[`UHR_F_SUSP]) st_nxt.susp[psel] = 1'b1; // [R13]
              if (wdata_in[`UHR_F_POVL]) st_nxt.susp[psel] = 1'b0; // [R13]
              if (wdata_in[`UHR_F_RES]) begin
                st_nxt.en[psel] = 1'b1; // [R13]
                st_nxt.susp[psel] = 1'b0;
              end
            end
          end
        end
        default: begin
          st_nxt.rdata = 32'h0;
        end
      endcase
    end
    // ----------------------------------------
    // power and overload
    // ----------------------------------------
    if (ovl_rise) begin
      st_nxt.ovl_chg = 1'b1; // [R16]
      st_nxt.global_on = 1'b0; // [R16]
      st_nxt.port_pwr = 2'h0; // [R16]
    end
    for (int i = 0; i < 2; i++) begin
      // always-on config masks the overload power drop
      if (st_r.always_on) begin
        st_nxt.sup[i] = 1'b1; // [R14] [R16]
      end else if (st_r.scheme & st_r.mask[i]) begin
        st_nxt.sup[i] = st_nxt.port_pwr[i]; // [R14]
      end else begin
        st_nxt.sup[i] = st_nxt.global_on; // [R14]
      end
    end
    // ----------------------------------------
    // attach and detach
    // ----------------------------------------
    for (int i = 0; i < 2; i++) begin
      se0 = ~st_r.dp_f[i] & ~st_r.dm_f[i];
      if (!st_r.sup[i]) begin
        st_nxt.conn[i] = 1'b0; // [R22]
        st_nxt.en[i] = 1'b0;
        st_nxt.susp[i] = 1'b0;
        st_nxt.att[i] = 9'h0;
      end else if (st_r.drv[i] || (se0 != st_r.conn[i])) begin
        st_nxt.att[i] = 9'h0;
      end else if (st_r.att[i] == 9'(`UHR_ATT_CYC - 1)) begin
        st_nxt.att[i] = 9'h0;
        st_nxt.chg[i] = 1'b1; // [R23]
        st_nxt.conn[i] = ~se0; // [R22] [R23]
        if (se0) begin
          st_nxt.en[i] = 1'b0;
          st_nxt.susp[i] = 1'b0;
        end else begin
          st_nxt.ls[i] = st_r.dm_f[i]; // [R22]
        end
        wake_ev = wake_ev | st_r.wake_en; // [R20]
      end else begin
        st_nxt.att[i] = st_r.att[i] + 9'h1;
      end
      kst = st_r.ls[i] ? (st_r.dp_f[i] & ~st_r.dm_f[i])
                       : (~st_r.dp_f[i] & st_r.dm_f[i]);
      if (kst & st_r.conn[i] & (st_r.en[i] | st_r.susp[i]) & ~st_r.drv[i]) begin
        wake_ev = 1'b1; // [R20]
      end
    end
    // ----------------------------------------
    // sleep, wake and bit tick
    // ----------------------------------------
    if (ctrl_state_in == uhr_pkg::CTRL_SLEEP) begin
      st_nxt.tick = 1'b0; // [R18]
      if (wake_ev & ~st_r.wake_req) begin
        st_nxt.wake_irq = 1'b1; // [R20]
        st_nxt.wake_req = 1'b1; // [R20]
      end
    end else begin
      st_nxt.wake_req = 1'b0;
      // 12 of every 100 clocks carry a tick
      if (st_r.acc >= 7'h58) begin
        st_nxt.acc = st_r.acc - 7'h58;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.acc = st_r.acc + 7'h0C;
        st_nxt.tick = 1'b0;
      end
    end
    // ----------------------------------------
    // low-speed eop
    // ----------------------------------------
    eop_go = (ctrl_state_in == uhr_pkg::CTRL_RUNNING)
             & (sof_request_in | (st_r.ctrl_prev == uhr_pkg::CTRL_WAKE_SIG));
    st_nxt.ctrl_prev = ctrl_state_in;
    case (st_r.eop)
      uhr_pkg::EOP_IDLE: begin
        if (eop_go) begin
          st_nxt.eop = uhr_pkg::EOP_SE0; // [R21]
          st_nxt.eop_cnt = 8'h0;
          st_nxt.eop_res = ~sof_request_in;
        end
      end
      uhr_pkg::EOP_SE0: begin
        st_nxt.eop_cnt = st_r.eop_cnt + 8'h1;
        if (st_r.eop_cnt == 8'(`UHR_SE0_CYC - 1)) begin
          st_nxt.eop = uhr_pkg::EOP_J; // [R21]
          st_nxt.eop_cnt = 8'h0;
        end
      end
      uhr_pkg::EOP_J: begin
        st_nxt.eop_cnt = st_r.eop_cnt + 8'h1;
        if (st_r.eop_cnt == 8'(`UHR_J_CYC - 1)) begin
          st_nxt.eop = uhr_pkg::EOP_IDLE; // [R21]
          st_nxt.eop_res = 1'b0;
        end
      end
      default: begin
        st_nxt.eop = uhr_pkg::EOP_IDLE;
      end
    endcase
    // resume eop blocks the engine until it ends
    st_nxt.pkt_ok = (ctrl_state_in == uhr_pkg::CTRL_RUNNING)
                    & ~(st_nxt.eop_res & (st_nxt.eop != uhr_pkg::EOP_IDLE)); // [R18] [R21]
    for (int i = 0; i < 2; i++) begin
      st_nxt.drv[i] = st_r.conn[i] & st_r.en[i] & ~st_r.susp[i];
      if (ctrl_state_in == uhr_pkg::CTRL_WAKE_SIG) begin
        st_nxt.line[i].dp = st_r.ls[i]; // [R19]
        st_nxt.line[i].dm = ~st_r.ls[i]; // [R19]
      end else if (st_nxt.eop == uhr_pkg::EOP_J) begin
        st_nxt.line[i].dp = ~st_r.ls[i]; // [R21]
        st_nxt.line[i].dm = st_r.ls[i]; // [R21]
      end else begin
        st_nxt.line[i] = '0;
        st_nxt.drv[i] = st_nxt.drv[i] & (st_nxt.eop == uhr_pkg::EOP_SE0);
      end
    end
    // ----------------------------------------
    // register reads
    // ----------------------------------------
    if (rd_in) begin
      pa = {1'b0, addr_in == `UHR_A_P1};
      case (addr_in)
        `UHR_A_CFGA: begin
          st_nxt.rdata[`UHR_F_SCHEME] = st_r.scheme;
          st_nxt.rdata[`UHR_F_ALWAYS] = st_r.always_on;
          st_nxt.rdata[`UHR_F_GSCHEME] = st_r.g_scheme;
          st_nxt.rdata[`UHR_F_GOFF] = st_r.g_off;
        end
        `UHR_A_CFGB: st_nxt.rdata[`UHR_F_MASK0+:2] = st_r.mask;
        `UHR_A_HUB: begin
          st_nxt.rdata[`UHR_F_HOVL] = st_r.ovl_f; // [R15]
          st_nxt.rdata[`UHR_F_HCHG] = st_r.ovl_chg;
          st_nxt.rdata[`UHR_F_WAKEEN] = st_r.wake_en;
        end
        `UHR_A_P0, `UHR_A_P1: begin
          st_nxt.rdata[`UHR_F_CONN] = st_r.conn[pa[0]];
          st_nxt.rdata[`UHR_F_EN] = st_r.en[pa[0]];
          st_nxt.rdata[`UHR_F_SUSP] = st_r.susp[pa[0]];
          st_nxt.rdata[`UHR_F_POVL] = st_r.g_scheme & ~st_r.g_off & st_r.ovl_f; // [R15]
          st_nxt.rdata[`UHR_F_PON] = st_r.sup[pa[0]];
          st_nxt.rdata[`UHR_F_POFF] = st_r.ls[pa[0]];
          st_nxt.rdata[`UHR_F_PCHG] = st_r.chg[pa[0]];
        end
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    // ----------------------------------------
    // bus reset state
    // ----------------------------------------
    if (ctrl_state_in == uhr_pkg::CTRL_BUS_RESET) begin
      st_nxt = rst_val(); // [R17]
      st_nxt.scheme = keep.scheme; // [R17]
      st_nxt.always_on = keep.always_on;
      st_nxt.g_scheme = keep.g_scheme;
      st_nxt.g_off = keep.g_off;
      st_nxt.mask = keep.mask;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r <= rst_val();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign result_out = st_r.result;
  assign retire_out = st_r.retire;
  assign ack_out = st_r.ack;
  assign force_stuff_out = st_r.force_stuff;
  assign line_out = st_r.line;
  assign line_oe_out = st_r.drv;
  assign global_supply_switch_out = st_r.global_on;
  assign port_supply_out = st_r.sup;
  assign bit_tick_out = st_r.tick;
  assign packets_allowed_out = st_r.pkt_ok;
  assign wake_seen_interrupt_out = st_r.wake_irq;
  assign wake_request_out = st_r.wake_req;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in || ctrl_state_in == uhr_pkg::CTRL_BUS_RESET);

  chk_in_eof_first: assert property ( // [R9]
    eng_in.done && eng_in.phase == uhr_pkg::PH_IN_DATA && eng_in.eof
    |=> result_out == `UHR_C_EOF && retire_out && !ack_out)
    else $error("in eof not top priority");
  chk_timeout_code: assert property ( // [R4]
    eng_in.done && eng_in.phase == uhr_pkg::PH_IN_DATA && !eng_in.eof
    && eng_in.timeout |=> result_out == `UHR_C_NORSP)
    else $error("time-out code wrong");
  chk_ack_cases: assert property ( // [R10]
    ack_out |-> result_out inside {`UHR_C_OK, `UHR_C_TOG, `UHR_C_OVER, `UHR_C_UNDER})
    else $error("ack with wrong status");
  chk_no_reserved: assert property ( // [R6]
    !(result_out inside {4'hA, 4'hB}))
    else $error("reserved code made");
  chk_underrun_wait: assert property ( // [R11]
    eng_in.done && eng_in.phase == uhr_pkg::PH_OUT_DATA && !eng_in.eof
    && eng_in.buf_und |=> force_stuff_out && !retire_out && result_out == `UHR_C_BUND)
    else $error("underrun not forced");
  chk_overload_off: assert property ( // [R16]
    ovl_rise && !st_r.always_on |=> !global_supply_switch_out ##1 !(|port_supply_out))
    else $error("overload kept power");
  chk_sleep_tick: assert property ( // [R18]
    ctrl_state_in == uhr_pkg::CTRL_SLEEP |=> !bit_tick_out && !packets_allowed_out)
    else $error("tick in sleep");
  chk_sof_eop: assert property ( // [R21]
    st_r.eop == uhr_pkg::EOP_IDLE && eop_go |=> st_r.eop == uhr_pkg::EOP_SE0
    ##(`UHR_SE0_CYC) st_r.eop == uhr_pkg::EOP_J)
    else $error("eop se0 length wrong");
  chk_unpowered: assert property ( // [R22]
    !port_supply_out[0] |=> !st_r.conn[0])
    else $error("unpowered port attached");
  cov_in_ok: cover property (retire_out && result_out == `UHR_C_OK);
  cov_wake: cover property (wake_seen_interrupt_out);
  cov_attach: cover property (st_r.conn[0] && !$past(st_r.conn[0]));
  cov_eop_j: cover property (st_r.eop == uhr_pkg::EOP_J);
endmodule : uhr_top

// ==== test/uhr_dev_model.sv ====
// uhr_dev_model: one attached downstream device on a root hub port
// assumes the host's levels arrive together with its output enable
`timescale 1ns/1ps
module uhr_dev_model #(
  parameter bit LS = 1'b0
) (
  input  wire logic          host_oe_in,
  input  uhr_pkg::uhr_line_s host_line_in,
  output uhr_pkg::uhr_line_s line_out
);
  // host wins while driving; otherwise idle level shows the speed
  always_comb begin
    if (host_oe_in)
      line_out = host_line_in;
    else
      line_out = LS ? 2'h1 : 2'h2;
  end
endmodule : uhr_dev_model

// ==== test/uhr_top_tb.sv ====
// uhr_top_tb: self-checking bench of the status encoder and root hub
// assumes the hand-over register map, 100 MHz clock, sync reset
`include "uhr_cfg.svh"
`timescale 1ns/1ps
module uhr_top_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sof = 1'b0, ovl = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] result;
  logic retire, ack, fst, gsw, tick, pkt, wirq, wreq;
  logic [1:0] oe, psup;
  uhr_pkg::uhr_ctrl_e ctrl = uhr_pkg::CTRL_RUNNING;
  uhr_pkg::uhr_eng_s eng = '0;
  uhr_pkg::uhr_line_s [1:0] lin, lout;
  int err_count = 0, checks_done = 0, cycles = 0;
  // four-state so an unknown tick shows up in the count
  logic [31:0] n;
  // {phase, iso, flags}, code, {retire, ack, force}
  localparam logic [23:0] TAB [20] = '{24'h000006, 24'h1800E4, 24'h0C0054, 24'h040014,
    24'h020024, 24'h010064, 24'h008074, 24'h0050C4, 24'h001836, 24'h0008F4, 24'h000444,
    24'h200844, 24'h000286, 24'h000196, 24'h4020D1, 24'h5000E4, 24'h9800E4, 24'h8C0054,
    24'h800444, 24'h800004};
  always #5 clk = ~clk;
  uhr_top i_dut (.clock_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ctrl_state_in(ctrl), .sof_request_in(sof),
    .eng_in(eng), .result_out(result), .retire_out(retire), .ack_out(ack),
    .force_stuff_out(fst), .overload_sense_in(ovl), .line_in(lin), .line_out(lout),
    .line_oe_out(oe), .global_supply_switch_out(gsw), .port_supply_out(psup),
    .bit_tick_out(tick), .packets_allowed_out(pkt), .wake_seen_interrupt_out(wirq),
    .wake_request_out(wreq));
  uhr_dev_model #(.LS(1'b0)) i_fs (.host_oe_in(oe[0]), .host_line_in(lout[0]),
    .line_out(lin[0]));
  uhr_dev_model #(.LS(1'b1)) i_ls (.host_oe_in(oe[1]), .host_line_in(lout[1]),
    .line_out(lin[1]));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_t(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_t
  task automatic rd_t(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_t
  task automatic ticks(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1 n += 32'(tick) + 32'(pkt && ctrl == uhr_pkg::CTRL_SLEEP);
    end
  endtask : ticks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ceiling well above the roughly 1260 cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end
  task automatic t_codes();
    foreach (TAB[i]) begin
      @(posedge clk);
      eng <= {1'b1, TAB[i][23:8]};
      @(posedge clk);
      eng <= '0;
      #1 chk(32'(result), 32'(TAB[i][7:4]));
      chk(32'({retire, ack, fst}), 32'(TAB[i][2:0]));
    end
  endtask : t_codes
  task automatic t_power();
    wr_t(`UHR_A_CFGA, 32'h0);
    wr_t(`UHR_A_HUB, 32'h0001_0000);
    @(posedge clk);
    #1 chk(32'({gsw, psup}), 32'h7);
    repeat (270) @(posedge clk);
    rd_t(`UHR_A_P0);
    chk(d & 32'h201, 32'h1);
    rd_t(`UHR_A_P1);
    chk(d & 32'h201, 32'h201);
    wr_t(`UHR_A_P0, 32'h2);
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    #1 chk(32'({oe, lout[0]}), 32'h4);
    repeat (134) @(posedge clk);
    #1 chk(32'({oe[0], lout[0]}), 32'h6);
    repeat (67) @(posedge clk);
    #1 chk(32'(oe), 32'h0);
    ticks(100);
    chk(n, 12);
    ctrl <= uhr_pkg::CTRL_SLEEP;
    repeat (3) @(posedge clk);
    ticks(100);
    chk(n, 0);
    ctrl <= uhr_pkg::CTRL_RUNNING;
  endtask : t_power
  task automatic t_fault();
    @(posedge clk);
    ovl <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(32'(psup), 32'h0);
    rd_t(`UHR_A_HUB);
    chk(d & 32'h2_0002, 32'h2_0002);
    @(posedge clk);
    ovl <= 1'b0;
    wr_t(`UHR_A_CFGA, 32'h100);
    @(posedge clk);
    ctrl <= uhr_pkg::CTRL_BUS_RESET;
    repeat (2) @(posedge clk);
    ctrl <= uhr_pkg::CTRL_RUNNING;
    rd_t(`UHR_A_CFGA);
    chk(d & 32'h100, 32'h100);
    rd_t(`UHR_A_HUB);
    chk(d & 32'h2_0000, 32'h0);
    rd_t(8'h40);
    chk(d, 32'h0);
  endtask : t_fault
  // attach while asleep with wake enabled, then resume k and its ls eop
  task automatic t_wake();
    logic [31:0] k;
    k = 0;
    @(posedge clk);
    ctrl <= uhr_pkg::CTRL_SLEEP;
    wr_t(`UHR_A_HUB, 32'h0001_8000);
    repeat (300) begin
      @(posedge clk);
      #1 k += 32'(wirq);
    end
    chk(k, 32'h1);
    chk(32'(wreq), 32'h1);
    wr_t(`UHR_A_P0, 32'h2);
    ctrl <= uhr_pkg::CTRL_WAKE_SIG;
    @(posedge clk);
    ctrl <= uhr_pkg::CTRL_RUNNING;
    #1 chk(32'({oe, lout[0], wreq}), 32'hA);
    @(posedge clk);
    #1 chk(32'({oe, lout[0], pkt}), 32'h8);
    repeat (201) @(posedge clk);
    #1 chk(32'(pkt), 32'h1);
  endtask : t_wake
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_codes();
    t_power();
    t_fault();
    t_wake();
    close_out();
  end
endmodule : uhr_top_tb
